// *** include/gpm_pkg.sv ***
package gpm_pkg;
  // timebase
  localparam int CLK_KHZ = 125000;
  localparam int CONV_PERIOD_MS = 880;
  localparam int CONV_CYCLES = CONV_PERIOD_MS * CLK_KHZ;
  localparam int BUS_LOW_MIN_MS = 1500;
  localparam int BUS_LOW_MAX_MS = 2200;
  // shortest legal timeout; whole ms times whole kHz needs no rounding
  localparam int BUS_LOW_CYCLES = BUS_LOW_MIN_MS * CLK_KHZ;
  localparam int CNT_W = 28;

  // serial address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h5A;

  // register byte offsets
  localparam int REG_AW = 6;
  localparam int REG_NUM = 64;
  localparam logic [5:0] OFS_CFG = 6'h01;
  localparam logic [5:0] OFS_CAP = 6'h02;
  localparam logic [5:0] OFS_AUX0 = 6'h08;
  localparam logic [5:0] OFS_AUX1 = 6'h0A;
  localparam logic [5:0] OFS_VOLT = 6'h0C;
  localparam logic [5:0] OFS_CURR = 6'h0E;
  localparam logic [5:0] OFS_TEMP = 6'h10;
  localparam logic [5:0] OFS_ACC = 6'h12;
  localparam logic [5:0] OFS_SCALE = 6'h14;
  localparam logic [5:0] OFS_PROF = 6'h20;
  localparam int PROF_BASE = 32;
  localparam int PROF_LEN = 16;

  // config fields and reset values
  localparam int CFG_TEMP_BIT = 0;
  localparam int CFG_SLEEP_BIT = 1;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h80;
  localparam int PROF_STEP = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_PTR = 3'h2,
    ST_WRITE = 3'h3,
    ST_READ = 3'h4,
    ST_SKIP = 3'h5
  } gpm_bus_state_e;
endpackage

// *** core/gpm_link_capture.sv ***
`timescale 1ns/1ps
// runs on the serial clock; that clock stops between frames, so nothing
// here waits for a later edge: each rise just hands one bit across
module gpm_link_capture (
  input wire logic scl,
  input wire logic rst_n,
  input wire logic sda_in,
  output logic bit_val,
  output logic bit_tgl
);

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_val <= 1'b0;
      bit_tgl <= 1'b0;
    end else begin
      bit_val <= sda_in;
      bit_tgl <= ~bit_tgl;
    end
  end

endmodule

// *** core/gpm_core.sv ***
`timescale 1ns/1ps
module gpm_core #(
  parameter int CONV_CYCLES = gpm_pkg::CONV_CYCLES,
  parameter int BUS_LOW_CYCLES = gpm_pkg::BUS_LOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic [11:0] volt_result,
  input wire logic [15:0] curr_result,
  input wire logic [10:0] aux0_result,
  input wire logic [10:0] aux1_result,
  input wire logic [10:0] temp_result,
  output logic active_mode,
  output logic meas_sample,
  output logic sleep_mode_enable,
  output logic internal_temp_select,
  output logic [7:0] capacity
);

  localparam int CW = gpm_pkg::CNT_W;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  localparam logic [CW-1:0] LOW_LAST = CW'(BUS_LOW_CYCLES - 1);

  logic rst_meta_n, rst_sn;
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic tgl_meta, tgl_sync, tgl_prev;
  logic bit_val, bit_tgl;
  logic [7:0] regs [gpm_pkg::REG_NUM];
  logic [CW-1:0] conv_cnt, low_cnt;
  logic aux_slot, meas_take, bus_low;
  logic signed [31:0] acc;
  logic signed [31:0] next_acc;
  logic signed [40:0] acc_weighted;
  logic [7:0] prof_entry;
  gpm_pkg::gpm_bus_state_e bus_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx;
  logic [5:0] ptr;
  logic bit_evt, start_det, stop_det, scl_fall, ack_ok, bus_wr;

  // reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sn <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sn <= rst_meta_n;
    end
  end

  // bus pins and the link toggle, two flops each before use
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_prev <= 1'b0;
    end else begin
      scl_meta <= scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      tgl_meta <= bit_tgl;
      tgl_sync <= tgl_meta;
      tgl_prev <= tgl_sync;
    end
  end

  // the serial clock only clocks this capture; it is never driven
  gpm_link_capture u_link (
    .scl(scl),
    .rst_n(rst_n),
    .sda_in(sda_in),
    .bit_val(bit_val),
    .bit_tgl(bit_tgl)
  );

  assign bus_low = !scl_sync && !sda_sync;
  assign sleep_mode_enable = regs[gpm_pkg::OFS_CFG][gpm_pkg::CFG_SLEEP_BIT];
  assign internal_temp_select = regs[gpm_pkg::OFS_CFG][gpm_pkg::CFG_TEMP_BIT];
  assign capacity = regs[gpm_pkg::OFS_CAP];

  // bus low timer
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      low_cnt <= '0;
    end else if (!bus_low || !sleep_mode_enable || !active_mode) begin
      low_cnt <= '0;
    end else if (low_cnt != LOW_LAST) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // power mode; comes out of reset active
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      active_mode <= 1'b1;
    end else if (!active_mode) begin
      if (scl_sync || sda_sync) begin
        active_mode <= 1'b1;
      end
    end else if (sleep_mode_enable && bus_low && low_cnt == LOW_LAST) begin
      active_mode <= 1'b0;
    end
  end

  // conversion timebase, frozen in sleep so a cycle resumes where it stopped
  assign meas_take = active_mode && conv_cnt == CONV_LAST;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      conv_cnt <= '0;
    end else if (active_mode) begin
      conv_cnt <= (conv_cnt == CONV_LAST) ? '0 : conv_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      aux_slot <= 1'b0;
      meas_sample <= 1'b0;
    end else begin
      meas_sample <= meas_take;
      if (meas_take) begin
        aux_slot <= ~aux_slot;
      end
    end
  end

  // coulomb counter, weighted by the live scale register
  assign next_acc = acc + 32'(signed'(curr_result));
  assign acc_weighted = next_acc * $signed({1'b0, regs[gpm_pkg::OFS_SCALE]});
  assign prof_entry = regs[6'(gpm_pkg::PROF_BASE) + {2'h0, volt_result[11:8]}];

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      acc <= '0;
    end else if (meas_take) begin
      acc <= next_acc;
    end
  end

  // serial bus decode
  assign bit_evt = tgl_sync ^ tgl_prev;
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign scl_fall = scl_prev && !scl_sync;
  assign ack_ok = (bus_state == gpm_pkg::ST_ADDR &&
                   shreg[7:1] == gpm_pkg::DEV_ADDR) ||
                  bus_state == gpm_pkg::ST_PTR ||
                  bus_state == gpm_pkg::ST_WRITE;
  assign bus_wr = bit_evt && bit_cnt == 4'h8 &&
                  bus_state == gpm_pkg::ST_WRITE;

  // access is never gated by the power mode
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      bus_state <= gpm_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'hFF;
      ptr <= 6'h00;
    end else if (start_det) begin
      bus_state <= gpm_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_det) begin
      bus_state <= gpm_pkg::ST_IDLE;
    end else if (bit_evt && bus_state != gpm_pkg::ST_IDLE) begin
      if (bit_cnt != 4'h8) begin
        shreg <= {shreg[6:0], bit_val};
        tx <= {tx[6:0], 1'b1};
        bit_cnt <= bit_cnt + 4'h1;
      end else begin
        bit_cnt <= 4'h0;
        case (bus_state)
          gpm_pkg::ST_ADDR: begin
            if (shreg[7:1] != gpm_pkg::DEV_ADDR) begin
              bus_state <= gpm_pkg::ST_SKIP;
            end else if (shreg[0]) begin
              bus_state <= gpm_pkg::ST_READ;
              tx <= regs[ptr];
              ptr <= ptr + 6'h01;
            end else begin
              bus_state <= gpm_pkg::ST_PTR;
            end
          end
          gpm_pkg::ST_PTR: begin
            ptr <= shreg[5:0];
            bus_state <= gpm_pkg::ST_WRITE;
          end
          gpm_pkg::ST_WRITE: begin
            ptr <= ptr + 6'h01;
          end
          gpm_pkg::ST_READ: begin
            if (bit_val) begin
              bus_state <= gpm_pkg::ST_SKIP;
            end else begin
              tx <= regs[ptr];
              ptr <= ptr + 6'h01;
            end
          end
          default: begin
            bus_state <= gpm_pkg::ST_SKIP;
          end
        endcase
      end
    end
  end

  // data line: only ever pulled low, changed just after the clock falls or released on a start or stop
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      sda_out <= 1'b0;
      sda_drive_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      if (start_det || stop_det) begin
        sda_drive_n <= 1'b1;
      end else if (scl_fall) begin
        if (bit_cnt == 4'h8) begin
          sda_drive_n <= !ack_ok;
        end else begin
          sda_drive_n <= !(bus_state == gpm_pkg::ST_READ && !tx[7]);
        end
      end
    end
  end

  // register file; a result landing with a host write to the same byte wins
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      for (int i = 0; i < gpm_pkg::REG_NUM; i++) begin
        regs[i] <= (i >= gpm_pkg::PROF_BASE &&
                    i < gpm_pkg::PROF_BASE + gpm_pkg::PROF_LEN) ?
                   8'((i - gpm_pkg::PROF_BASE + 1) * gpm_pkg::PROF_STEP) :
                   8'h00;
      end
      regs[gpm_pkg::OFS_CFG] <= gpm_pkg::CFG_RST;
      regs[gpm_pkg::OFS_SCALE] <= gpm_pkg::SCALE_RST;
    end else begin
      if (bus_wr) begin
        regs[ptr] <= shreg;
      end
      if (meas_take) begin
        {regs[gpm_pkg::OFS_VOLT], regs[gpm_pkg::OFS_VOLT + 6'h01]} <=
          {1'b0, volt_result, 3'h0};
        {regs[gpm_pkg::OFS_CURR], regs[gpm_pkg::OFS_CURR + 6'h01]} <=
          curr_result;
        {regs[gpm_pkg::OFS_ACC], regs[gpm_pkg::OFS_ACC + 6'h01]} <=
          acc_weighted[23:8];
        regs[gpm_pkg::OFS_CAP] <= 8'(prof_entry + acc_weighted[23:16]);
        if (!aux_slot) begin
          {regs[gpm_pkg::OFS_AUX0], regs[gpm_pkg::OFS_AUX0 + 6'h01]} <=
            {1'b0, aux0_result, 4'h0};
        end else if (internal_temp_select) begin
          {regs[gpm_pkg::OFS_TEMP], regs[gpm_pkg::OFS_TEMP + 6'h01]} <=
            {temp_result, 5'h00};
        end else begin
          {regs[gpm_pkg::OFS_AUX1], regs[gpm_pkg::OFS_AUX1 + 6'h01]} <=
            {1'b0, aux1_result, 4'h0};
        end
      end
    end
  end

  property p_wake;
    @(posedge clk) disable iff (!rst_sn)
    !active_mode && (scl_sync || sda_sync) |=> active_mode;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on line high");
  property p_stay_awake;
    @(posedge clk) disable iff (!rst_sn)
    active_mode && !sleep_mode_enable |=> active_mode;
  endproperty
  a_stay_awake: assert property (p_stay_awake)
    else $error("slept with sleep disabled");
  property p_timeout;
    @(posedge clk) disable iff (!rst_sn)
    $fell(active_mode) |-> $past(low_cnt) == LOW_LAST && $past(bus_low);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("sleep before full bus low timeout");
  property p_low_clear;
    @(posedge clk) disable iff (!rst_sn)
    (scl_sync || sda_sync || !sleep_mode_enable) |=> low_cnt == '0;
  endproperty
  a_low_clear: assert property (p_low_clear)
    else $error("timeout counter not cleared");
  property p_sleep_frozen;
    @(posedge clk) disable iff (!rst_sn)
    !active_mode |=> !meas_sample && $stable(acc) && $stable(conv_cnt);
  endproperty
  a_sleep_frozen: assert property (p_sleep_frozen)
    else $error("measurement activity in sleep");
  property p_accumulate;
    @(posedge clk) disable iff (!rst_sn)
    meas_take |=> acc == $past(acc) + 32'(signed'($past(curr_result)));
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("accumulator did not add current");
  property p_curr_reg;
    @(posedge clk) disable iff (!rst_sn)
    meas_take |=> {regs[gpm_pkg::OFS_CURR], regs[gpm_pkg::OFS_CURR + 6'h01]}
      == $past(curr_result) ##1 !meas_sample;
  endproperty
  a_curr_reg: assert property (p_curr_reg)
    else $error("current register not updated");
  property p_temp_slot;
    @(posedge clk) disable iff (!rst_sn)
    meas_take && aux_slot && internal_temp_select |=>
      $stable(regs[gpm_pkg::OFS_AUX1]) &&
      {regs[gpm_pkg::OFS_TEMP], regs[gpm_pkg::OFS_TEMP + 6'h01]} ==
      {$past(temp_result), 5'h00};
  endproperty
  a_temp_slot: assert property (p_temp_slot)
    else $error("temperature did not take aux 1 slot");
  property p_open_drain;
    @(posedge clk) disable iff (!rst_sn)
    !sda_out and ($changed(sda_drive_n) |-> $past(scl_fall) ||
      $past(start_det) || $past(stop_det));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high or off a clock fall");
  property p_write;
    @(posedge clk) disable iff (!rst_sn)
    bus_wr && !meas_take |=> regs[$past(ptr)] == $past(shreg);
  endproperty
  a_write: assert property (p_write) else $error("bus write lost");

endmodule

// *** verification/gpm_host_model.sv ***
`timescale 1ns/1ps
// two-wire host; scl stands high between frames, 80 ns per bit
module gpm_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data only ever pulled low; the pull-up makes the high level
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = ~b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0; // each low lasts 40 ns, far under the timeout
  endtask
  task automatic start();
    sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #120;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
  // only on command: both lines parked low so the device may sleep
  task automatic park();
    sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic wake();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #120;
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, scl, host_low, sda, sda_out, sda_drive_n;
  logic [11:0] volt;
  logic [15:0] curr;
  logic [10:0] aux0, aux1, temp;
  logic active_mode, meas_sample, sleep_mode_enable, internal_temp_select;
  logic [7:0] capacity;
  logic [7:0] rbuf [0:15];
  logic [31:0] seed = 32'h00017591;
  int bad_count, n_compared;

  // pull-up on the data line; low when either party pulls
  assign sda = (host_low | ~sda_drive_n) ? 1'b0 : 1'b1;

  gpm_core #(.CONV_CYCLES(200), .BUS_LOW_CYCLES(100)) gpm_core_i (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_drive_n(sda_drive_n),
    .volt_result(volt), .curr_result(curr), .aux0_result(aux0),
    .aux1_result(aux1), .temp_result(temp), .active_mode(active_mode),
    .meas_sample(meas_sample), .sleep_mode_enable(sleep_mode_enable),
    .internal_temp_select(internal_temp_select), .capacity(capacity)
  );
  gpm_host_model gpm_host_model_i (
    .scl(scl), .sda_low(host_low), .sda(sda)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_volt(input logic [11:0] v);
    return {1'b0, v, 3'h0};
  endfunction
  function automatic logic [15:0] exp_aux(input logic [10:0] a);
    return {1'b0, a, 4'h0};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic a0, a1, a2;
    gpm_host_model_i.start();
    gpm_host_model_i.send(8'hB4, a0);
    gpm_host_model_i.send(ofs, a1);
    gpm_host_model_i.send(d, a2);
    gpm_host_model_i.stop();
    check({13'h0000, a0, a1, a2}, 16'h0000);
  endtask
  task automatic rd(input logic [7:0] ofs, input int n);
    logic a;
    gpm_host_model_i.start();
    gpm_host_model_i.send(8'hB4, a);
    gpm_host_model_i.send(ofs, a);
    gpm_host_model_i.stop();
    gpm_host_model_i.start();
    gpm_host_model_i.send(8'hB5, a);
    for (int i = 0; i < n; i++) gpm_host_model_i.recv(i == n - 1, rbuf[i]);
    gpm_host_model_i.stop();
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wait_sample();
    for (int k = 0; k < 1000; k++) begin
      @(negedge clk);
      if (meas_sample === 1'b1) return;
    end
    bad_count++;
    end_of_test();
  endtask
  task automatic drive(input logic corner);
    logic [31:0] r;
    @(negedge clk);
    r = rnd();
    volt = corner ? 12'hFFF : r[11:0];
    curr = corner ? 16'h8000 : r[31:16];
    r = rnd();
    aux0 = corner ? 11'h7FF : r[10:0];
    aux1 = corner ? 11'h000 : r[26:16];
    r = rnd();
    temp = r[10:0];
  endtask

  initial begin
    logic a;
    logic [7:0] cap0;
    int k, pulses;
    rst_n = 1'b0;
    volt = 12'h000;
    curr = 16'h0000;
    aux0 = 11'h000;
    aux1 = 11'h000;
    temp = 11'h000;
    bad_count = 0;
    n_compared = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check({active_mode, sda_drive_n, sda_out, sleep_mode_enable,
           internal_temp_select}, 16'h0018);
    check(capacity, 16'h0000);
    // wrong address must go unanswered
    gpm_host_model_i.start();
    gpm_host_model_i.send(8'hAA, a);
    gpm_host_model_i.stop();
    check(a, 16'h0001);
    rd(8'h14, 1);
    check(rbuf[0], 16'h0080);
    rd(8'h20, 1);
    check(rbuf[0], 16'h0006);
    wr(8'h14, 8'h3C);
    rd(8'h14, 1);
    check(rbuf[0], 16'h003C);
    // two samples so both aux slots have refreshed
    for (int n = 0; n < 3; n++) begin
      drive(n == 0);
      wait_sample();
      wait_sample();
      rd(8'h08, 8);
      check({rbuf[0], rbuf[1]}, exp_aux(aux0));
      check({rbuf[2], rbuf[3]}, exp_aux(aux1));
      check({rbuf[4], rbuf[5]}, exp_volt(volt));
      check({rbuf[6], rbuf[7]}, curr);
    end
    wr(8'h01, 8'h01);
    check(internal_temp_select, 16'h0001);
    drive(1'b0);
    wait_sample();
    wait_sample();
    rd(8'h10, 2);
    check({rbuf[0], rbuf[1]}, {temp, 5'h00});
    // lines low with sleep disabled: stays active
    wr(8'h01, 8'h00);
    gpm_host_model_i.park();
    repeat (300) @(negedge clk);
    check(active_mode, 16'h0001);
    gpm_host_model_i.wake();
    wr(8'h01, 8'h02);
    check(sleep_mode_enable, 16'h0001);
    gpm_host_model_i.park();
    for (k = 0; k < 400 && active_mode === 1'b1; k++) @(negedge clk);
    check(k >= 100 && k <= 108, 16'h0001);
    cap0 = capacity;
    drive(1'b0);
    pulses = 0;
    repeat (500) begin
      @(negedge clk);
      if (meas_sample === 1'b1) pulses++;
    end
    check(pulses[15:0], 16'h0000);
    check({8'h00, capacity}, {8'h00, cap0});
    fork
      gpm_host_model_i.wake();
      for (k = 0; k < 8 && active_mode !== 1'b1; k++) @(negedge clk);
    join
    check(k < 8, 16'h0001);
    wait_sample();
    wait_sample();
    rd(8'h0C, 2);
    check({rbuf[0], rbuf[1]}, exp_volt(volt));
    check(sda_out, 16'h0000);
    end_of_test();
  end
endmodule
